// >>> otpsq_pkg.sv
// constants, field layouts and types shared by the otp operation sequencer
package otpsq_pkg;

    // store geometry
    localparam int STORE_BITS  = 40;
    localparam int WORD_BITS   = 10;
    localparam int LOCK_POS    = 39;
    localparam int CFG_HI_BITS = 7;

    // operation-select codes
    localparam logic [1:0] OP_NOP_LO  = 2'h0;
    localparam logic [1:0] OP_REFRESH = 2'h1;
    localparam logic [1:0] OP_BURN    = 2'h2;
    localparam logic [1:0] OP_NOP_HI  = 2'h3;

    // apb register byte offsets
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CFG_LO   = 8'h04;
    localparam logic [7:0] OFS_CFG_HI   = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0c;
    localparam logic [7:0] OFS_DATA     = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // field positions
    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_SEL_LSB = 4;
    localparam int CTRL_BIAS_L  = 8;
    localparam int CTRL_BIAS_H  = 9;
    localparam int ST_BUSY      = 0;
    localparam int ST_FAIL      = 1;
    localparam int ST_LOCK      = 2;
    localparam int ST_VALID     = 3;
    localparam int IRQ_BITS     = 3;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_FAIL     = 1;
    localparam int IRQ_REFUSED  = 2;

    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int READ_NS       = 1000;
    localparam int BURN_BIT_NS   = 10000;
    localparam int READ_CYC      = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BURN_CYC      = (BURN_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 16;

    typedef struct packed {
        logic       bias_h;
        logic       bias_l;
        logic [1:0] word_sel;
    } otpsq_ctrl_t;

    localparam otpsq_ctrl_t          CTRL_RST = '{bias_h: 1'b0, bias_l: 1'b0, word_sel: 2'h0};
    localparam logic [IRQ_BITS-1:0]  MASK_RST = 3'h0;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_REFRESH,
        SEQ_BURN
    } otpsq_seq_t;

    typedef enum logic [1:0] {
        FUSE_IDLE,
        FUSE_READ,
        FUSE_BURN
    } otpsq_fuse_t;

endpackage

// >>> otpsq_fuse_array.sv
// fuse array with timed sense and bit-serial burn
`timescale 1ns/100ps
`default_nettype none
module otpsq_fuse_array
    import otpsq_pkg::*;
#(
    parameter int W        = STORE_BITS,
    parameter int RD_CYC   = READ_CYC,
    parameter int BIT_CYC  = BURN_CYC
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // operation requests
    input  wire logic         read_req,
    input  wire logic         burn_req,
    input  wire logic [W-1:0] burn_word,
    // results
    output var  logic         done,
    output var  logic [W-1:0] sense_word,
    output var  logic         lock_bit
);

    otpsq_fuse_t      st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [5:0]       idx_q, idx_d;
    logic [W-1:0]     fuse_q, fuse_d;
    logic [W-1:0]     burn_q, burn_d;
    logic [W-1:0]     sense_q, sense_d;
    logic             done_q, done_d;

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        idx_d   = idx_q;
        fuse_d  = fuse_q;
        burn_d  = burn_q;
        sense_d = sense_q;
        done_d  = 1'b0;
        case (st_q)
            FUSE_IDLE: begin
                cnt_d = '0;
                idx_d = '0;
                if (read_req) begin
                    st_d = FUSE_READ;
                end else if (burn_req) begin
                    burn_d = burn_word;
                    st_d   = FUSE_BURN;
                end
            end
            FUSE_READ: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(RD_CYC - 1)) begin
                    sense_d = fuse_q;
                    done_d  = 1'b1;
                    st_d    = FUSE_IDLE;
                end
            end
            FUSE_BURN: begin
                // bits to be left blank cost no burn time
                if (!burn_q[idx_q] || cnt_q == CNT_W'(BIT_CYC - 1)) begin
                    fuse_d[idx_q] = fuse_q[idx_q] | burn_q[idx_q];
                    cnt_d         = '0;
                    idx_d         = idx_q + 1'b1;
                    if (idx_q == 6'(W - 1)) begin
                        done_d = 1'b1;
                        st_d   = FUSE_IDLE;
                    end
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: st_d = FUSE_IDLE;
        endcase
    end

    // fuses come up blank here; a real array keeps its state across reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q    <= FUSE_IDLE;
            cnt_q   <= '0;
            idx_q   <= '0;
            fuse_q  <= '0;
            burn_q  <= '0;
            sense_q <= '0;
            done_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            idx_q   <= idx_d;
            fuse_q  <= fuse_d;
            burn_q  <= burn_d;
            sense_q <= sense_d;
            done_q  <= done_d;
        end
    end

    assign done       = done_q;
    assign sense_word = sense_q;
    assign lock_bit   = fuse_q[LOCK_POS];

    fuse_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(fuse_q[LOCK_POS]) |-> fuse_q[LOCK_POS])
        else $error("lock fuse cleared after being set");

endmodule
`default_nettype wire

// >>> otpsq_sequencer.sv
// otp operation sequencer with apb register slave and interrupt
// Function
// - op codes 0 and 3 do nothing; store and readback stay unchanged
// - op code 1 reloads all 40 store bits into the readback shadow
// - readback shows the selected 10-bit word, valid only after refresh
// - op code 2 burns the configuration registers and lock bit
// - burn runs only while lock bit is blank; later burns refused
// - busy is high for the whole refresh or burn, then clears
// - boost undervoltage during a burn sets the fail flag
// - reading the status register clears the fail flag
// - lock bit is burned in the same operation as the configuration
// - readback under either bias setting equals programmed data
// - word-select 0..3 picks store bits 9:0, 19:10, 29:20, 39:30
// - lock bit sits at store bit 39 and blocks reprogramming
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module otpsq_sequencer
    import otpsq_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // analog side
    input  wire logic              burn_supply_undervolt_limit,
    output var  logic              read_bias_low,
    output var  logic              read_bias_high,
    // interrupt
    output var  logic              irq
);

    // apb handshake: one wait state, reads sampled in the wait cycle
    logic        acc, fin;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;

    // registers
    otpsq_ctrl_t               ctrl_q, ctrl_d;
    logic [31:0]               cfg_lo_q, cfg_lo_d;
    logic [CFG_HI_BITS-1:0]    cfg_hi_q, cfg_hi_d;
    logic [IRQ_BITS-1:0]       istat_q, istat_d;
    logic [IRQ_BITS-1:0]       imask_q, imask_d;
    logic                      fail_q, fail_d;
    logic                      irq_q, irq_d;

    // sequencer
    otpsq_seq_t                seq_q, seq_d;
    logic [STORE_BITS-1:0]     shadow_q, shadow_d;
    logic                      valid_q, valid_d;
    logic                      busy_q, busy_d;
    logic                      read_req, burn_req;
    logic                      arr_done, lock_bit;
    logic [STORE_BITS-1:0]     sense_word;
    logic                      uv_s1_q, uv_s2_q;
    logic                      op_wr;
    logic [1:0]                op_code;
    logic [IRQ_BITS-1:0]       ev;
    logic [WORD_BITS-1:0]      rd_word;
    logic                      mapped;

    assign acc     = psel && penable && !pready_q;
    assign fin     = psel && penable && pready_q;
    assign op_wr   = fin && pwrite && paddr == OFS_CTRL;
    assign op_code = pwdata[CTRL_OP_LSB +: 2];
    assign rd_word = shadow_q[ctrl_q.word_sel * WORD_BITS +: WORD_BITS];
    assign mapped  = paddr == OFS_CTRL || paddr == OFS_CFG_LO || paddr == OFS_CFG_HI
                  || paddr == OFS_STATUS || paddr == OFS_DATA || paddr == OFS_IRQ_STAT
                  || paddr == OFS_IRQ_MASK;

    otpsq_fuse_array #(
        .W       (STORE_BITS),
        .RD_CYC  (READ_CYC),
        .BIT_CYC (BURN_CYC)
    ) u_fuse (
        .pclk       (pclk),
        .presetn    (presetn),
        .read_req   (read_req),
        .burn_req   (burn_req),
        .burn_word  ({1'b1, cfg_hi_q, cfg_lo_q}),
        .done       (arr_done),
        .sense_word (sense_word),
        .lock_bit   (lock_bit)
    );

    // undervoltage comparator is asynchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_s1_q <= 1'b0;
            uv_s2_q <= 1'b0;
        end else begin
            uv_s1_q <= burn_supply_undervolt_limit;
            uv_s2_q <= uv_s1_q;
        end
    end

    // operation sequencing
    always_comb begin
        seq_d    = seq_q;
        shadow_d = shadow_q;
        valid_d  = valid_q;
        read_req = 1'b0;
        burn_req = 1'b0;
        ev       = '0;
        case (seq_q)
            SEQ_IDLE: begin
                if (op_wr) begin
                    if (op_code == OP_REFRESH) begin
                        read_req = 1'b1;
                        valid_d  = 1'b0;
                        seq_d    = SEQ_REFRESH;
                    end else if (op_code == OP_BURN && !lock_bit) begin
                        burn_req = 1'b1;
                        seq_d    = SEQ_BURN;
                    end else if (op_code == OP_BURN) begin
                        ev[IRQ_REFUSED] = 1'b1;
                    end
                    // codes 0 and 3 fall through untouched
                end
            end
            SEQ_REFRESH: begin
                if (arr_done) begin
                    shadow_d      = sense_word;
                    valid_d       = 1'b1;
                    ev[IRQ_DONE]  = 1'b1;
                    seq_d         = SEQ_IDLE;
                end
            end
            SEQ_BURN: begin
                if (uv_s2_q) begin
                    ev[IRQ_FAIL] = 1'b1;
                end
                if (arr_done) begin
                    ev[IRQ_DONE] = 1'b1;
                    seq_d        = SEQ_IDLE;
                end
            end
            default: seq_d = SEQ_IDLE;
        endcase
        // writes during an operation land in the branches above only when idle
        busy_d = seq_d != SEQ_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q    <= SEQ_IDLE;
            shadow_q <= '0;
            valid_q  <= 1'b0;
            busy_q   <= 1'b0;
        end else begin
            seq_q    <= seq_d;
            shadow_q <= shadow_d;
            valid_q  <= valid_d;
            busy_q   <= busy_d;
        end
    end

    // register file and apb answer
    always_comb begin
        ctrl_d    = ctrl_q;
        cfg_lo_d  = cfg_lo_q;
        cfg_hi_d  = cfg_hi_q;
        imask_d   = imask_q;
        istat_d   = istat_q;
        fail_d    = fail_q;
        pready_d  = acc;
        pslverr_d = acc && !mapped;
        prdata_d  = prdata_q;
        if (acc) begin
            prdata_d = '0;
            if (!pwrite) begin
                case (paddr)
                    OFS_CTRL: begin
                        prdata_d[CTRL_SEL_LSB +: 2] = ctrl_q.word_sel;
                        prdata_d[CTRL_BIAS_L]       = ctrl_q.bias_l;
                        prdata_d[CTRL_BIAS_H]       = ctrl_q.bias_h;
                    end
                    OFS_CFG_LO:   prdata_d = cfg_lo_q;
                    OFS_CFG_HI:   prdata_d[CFG_HI_BITS-1:0] = cfg_hi_q;
                    OFS_STATUS: begin
                        prdata_d[ST_BUSY]  = busy_q;
                        prdata_d[ST_FAIL]  = fail_q;
                        prdata_d[ST_LOCK]  = lock_bit;
                        prdata_d[ST_VALID] = valid_q;
                        // clear with the sampling edge so no later set is lost
                        fail_d = 1'b0;
                    end
                    OFS_DATA:     prdata_d[WORD_BITS-1:0] = valid_q ? rd_word : '0;
                    OFS_IRQ_STAT: prdata_d[IRQ_BITS-1:0]  = istat_q;
                    OFS_IRQ_MASK: prdata_d[IRQ_BITS-1:0]  = imask_q;
                    default:      prdata_d = '0;
                endcase
            end
        end
        if (fin && pwrite) begin
            case (paddr)
                OFS_CTRL: begin
                    if (!busy_q) begin
                        ctrl_d.word_sel = pwdata[CTRL_SEL_LSB +: 2];
                        ctrl_d.bias_l   = pwdata[CTRL_BIAS_L];
                        ctrl_d.bias_h   = pwdata[CTRL_BIAS_H];
                    end
                end
                OFS_CFG_LO:   cfg_lo_d = pwdata;
                OFS_CFG_HI:   cfg_hi_d = pwdata[CFG_HI_BITS-1:0];
                OFS_IRQ_STAT: istat_d  = istat_q & ~pwdata[IRQ_BITS-1:0];
                OFS_IRQ_MASK: imask_d  = pwdata[IRQ_BITS-1:0];
                default: ;
            endcase
        end
        // hardware set wins over any clear in the same cycle
        istat_d = istat_d | ev;
        fail_d  = fail_d | ev[IRQ_FAIL];
        irq_d   = |(istat_d & imask_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= CTRL_RST;
            cfg_lo_q  <= '0;
            cfg_hi_q  <= '0;
            imask_q   <= MASK_RST;
            istat_q   <= '0;
            fail_q    <= 1'b0;
            irq_q     <= 1'b0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            ctrl_q    <= ctrl_d;
            cfg_lo_q  <= cfg_lo_d;
            cfg_hi_q  <= cfg_hi_d;
            imask_q   <= imask_d;
            istat_q   <= istat_d;
            fail_q    <= fail_d;
            irq_q     <= irq_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign irq            = irq_q;
    assign read_bias_low  = ctrl_q.bias_l;
    assign read_bias_high = ctrl_q.bias_h;

    // checks
    sequence op_write_s(logic [1:0] code);
        seq_q == SEQ_IDLE && op_wr && op_code == code;
    endsequence

    sequence busy_hold_s;
        busy_q [*8];
    endsequence

    nop_keeps_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        op_write_s(OP_NOP_LO) or op_write_s(OP_NOP_HI) |=> seq_q == SEQ_IDLE && $stable(shadow_q))
        else $error("nop code started an operation");

    refresh_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        op_write_s(OP_REFRESH) |=> busy_hold_s ##1 busy_q)
        else $error("busy dropped early in refresh");

    refresh_loads_a: assert property (@(posedge pclk) disable iff (!presetn)
        seq_q == SEQ_REFRESH && arr_done |=> shadow_q == $past(sense_word) && valid_q && !busy_q)
        else $error("refresh did not load shadow");

    // sense runs READ_CYC cycles, plus one to load the shadow; early or late ends both fire
    refresh_length_a: assert property (@(posedge pclk) disable iff (!presetn)
        op_write_s(OP_REFRESH) |-> ##126 (seq_q == SEQ_REFRESH) ##1 (seq_q == SEQ_IDLE))
        else $error("refresh length wrong");

    data_invalid_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !pwrite && paddr == OFS_DATA && !valid_q |=> prdata_q == 32'h0)
        else $error("readback shown before refresh end");

    word_select_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !pwrite && paddr == OFS_DATA && valid_q
        |=> prdata_q[WORD_BITS-1:0] == WORD_BITS'($past(shadow_q) >> ($past(ctrl_q.word_sel) * WORD_BITS)))
        else $error("wrong readback word selected");

    burn_refused_a: assert property (@(posedge pclk) disable iff (!presetn)
        op_write_s(OP_BURN) && lock_bit |=> seq_q == SEQ_IDLE && istat_q[IRQ_REFUSED])
        else $error("burn accepted with lock set");

    burn_starts_a: assert property (@(posedge pclk) disable iff (!presetn)
        op_write_s(OP_BURN) && !lock_bit |=> seq_q == SEQ_BURN && busy_q)
        else $error("burn did not start");

    burn_locks_a: assert property (@(posedge pclk) disable iff (!presetn)
        seq_q == SEQ_BURN && arr_done |=> lock_bit)
        else $error("lock bit not set by burn");

    fail_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
        seq_q == SEQ_BURN && uv_s2_q |=> fail_q ##1 (fail_q || $past(acc && paddr == OFS_STATUS)))
        else $error("undervoltage did not set fail");

    fail_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !pwrite && paddr == OFS_STATUS && !(seq_q == SEQ_BURN && uv_s2_q) |=> !fail_q)
        else $error("status read left fail set");

    busy_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy_q && op_wr |=> $stable(ctrl_q) && seq_q != SEQ_IDLE || $past(arr_done))
        else $error("op write taken while busy");

endmodule
`default_nettype wire

// >>> otpsq_boost_model.sv
// boost supply model that sags below the burn limit on request
`timescale 1ns/100ps
`default_nettype none
module otpsq_boost_model (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // sag request from the bench
    input  wire logic droop_req,
    // comparator level seen by the sequencer
    output var  logic burn_supply_undervolt_limit
);
    logic [3:0] sag_q;
    logic [3:0] sag_d;
    // hold the sag well past the two-flop synchroniser so it cannot slip through
    always_comb begin
        sag_d = sag_q;
        if (droop_req) begin
            sag_d = 4'hf;
        end else if (sag_q != 4'h0) begin
            sag_d = sag_q - 4'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sag_q <= 4'h0;
        end else begin
            sag_q <= sag_d;
        end
    end
    always_comb begin
        burn_supply_undervolt_limit = (sag_q != 4'h0);
    end
endmodule
`default_nettype wire

// >>> test_otp_operation_sequencer.sv
// self-checking testbench for the otp operation sequencer
`timescale 1ns/100ps
`default_nettype none
module test_otp_operation_sequencer;
    import otpsq_pkg::*;
    localparam logic [31:0] CFG_LO_V = 32'h0000_0201;
    localparam logic [31:0] CFG_HI_V = 32'h0000_00c1;
    localparam logic [39:0] STORE_V  = {1'b1, CFG_HI_V[6:0], CFG_LO_V};
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              undervolt;
    logic              read_bias_low;
    logic              read_bias_high;
    logic              irq;
    logic              droop_req = 1'b0;
    int                mismatches = 0;
    int                checks_done = 0;

    always #4 pclk = ~pclk;

    otpsq_sequencer dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .burn_supply_undervolt_limit(undervolt), .read_bias_low(read_bias_low),
        .read_bias_high(read_bias_high), .irq(irq));
    otpsq_boost_model boost_u (
        .pclk(pclk), .presetn(presetn), .droop_req(droop_req), .burn_supply_undervolt_limit(undervolt));

    task automatic end_sim;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one transfer; entered just after a rising edge, leaves one idle edge behind
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait-state count is assumed; only the watchdog ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    // unmapped offsets above the mask register must answer with an error
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, a > OFS_IRQ_MASK});
    endtask

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 10000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 10000) mismatches++;
    endtask

    // refresh under one bias setting, then read back all four words
    task automatic verify(input logic [1:0] bias);
        wr(OFS_CTRL, {22'h0, bias, 6'h0, OP_REFRESH});
        wait_irq();
        wr(OFS_IRQ_STAT, 32'h7);
        for (int k = 0; k < 4; k++) begin
            wr(OFS_CTRL, {22'h0, bias, 2'h0, k[1:0], 2'h0, OP_NOP_LO});
            rd(OFS_DATA, {22'h0, STORE_V[k*10 +: 10]});
        end
        chk({30'h0, read_bias_high, read_bias_low}, {30'h0, bias});
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_DATA, 32'h0);
        rd(8'h1c, 32'h0);
        wr(OFS_CTRL, {22'h0, 2'h1, 2'h0, 2'h2, 2'h0, OP_NOP_HI});
        rd(OFS_CTRL, 32'h0000_0120);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_CTRL, {30'h0, OP_NOP_LO});
        rd(OFS_STATUS, 32'h0);
        wr(OFS_CTRL, {30'h0, OP_REFRESH});
        rd(OFS_STATUS, 32'h1);
        wr(OFS_CTRL, {30'h0, OP_BURN});
        // refresh length is fixed by the sequencer: 126 cycles
        repeat (140) @(posedge pclk);
        rd(OFS_STATUS, 32'h8);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_IRQ_STAT, 32'h1);
        wr(OFS_IRQ_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_STAT, 32'h7);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_DATA, 32'h0);
        wr(OFS_CFG_LO, CFG_LO_V);
        wr(OFS_CFG_HI, CFG_HI_V);
        rd(OFS_CFG_HI, {25'h0, CFG_HI_V[6:0]});
        wr(OFS_CTRL, {30'h0, OP_BURN});
        rd(OFS_STATUS, 32'h9);
        droop_req <= 1'b1;
        @(posedge pclk);
        droop_req <= 1'b0;
        wait_irq();
        rd(OFS_STATUS, 32'he);
        rd(OFS_STATUS, 32'hc);
        rd(OFS_IRQ_STAT, 32'h3);
        wr(OFS_IRQ_STAT, 32'h7);
        verify(2'h1);
        verify(2'h2);
        wr(OFS_CFG_LO, 32'hffff_ffff);
        wr(OFS_CTRL, {30'h0, OP_BURN});
        rd(OFS_STATUS, 32'hc);
        rd(OFS_IRQ_STAT, 32'h4);
        wr(OFS_IRQ_STAT, 32'h7);
        verify(2'h0);
        end_sim();
    end

    // the whole sequence takes well under forty thousand cycles
    initial begin
        repeat (40000) @(posedge pclk);
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
